// ===== logic/dis_irq_cell.sv
// one interrupt source: live view when disabled, rising-edge latch when enabled
`default_nettype none
module dis_irq_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic en,
  input  wire logic live,
  input  wire logic clr,
  // result
  output logic      status,
  output logic      latched
);
  import dis_pkg::*;

  logic live_q;
  logic latched_q;
  logic set_ev;

  assign set_ev = en & live & ~live_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_q <= 1'b0;
    end else begin
      live_q <= live;
    end
  end

  // set beats clear so an edge in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_q <= 1'b0;
    end else if (set_ev) begin
      latched_q <= 1'b1;
    end else if (!en || clr) begin
      latched_q <= 1'b0;
    end
  end

  assign status  = en ? latched_q : live;
  assign latched = latched_q;

  AST_CELL_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    en && live && !live_q |=> latched_q)
    else $error("enabled rising source not latched");
  AST_CELL_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
    !en |=> !latched_q)
    else $error("disabled source latched");
  AST_CELL_W1C: assert property (@(posedge clk) disable iff (!rst_n)
    latched_q && en && clr && !set_ev |=> !latched_q)
    else $error("write one did not clear flag");
  AST_CELL_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    latched_q && en && !clr |=> latched_q)
    else $error("latched flag dropped without clear");
endmodule // dis_irq_cell
`default_nettype wire

// ===== logic/dis_pkg.sv
// constants, types and decode helpers for the irq / tx-enable / power status block
`default_nettype none
package dis_pkg;
  // serial port framing
  localparam int unsigned DIS_AW          = 15;
  localparam int unsigned DIS_DW          = 8;
  localparam int unsigned DIS_CNT_W       = 5;
  localparam logic [4:0]  DIS_INSTR_LAST  = 5'h0F;
  localparam logic [4:0]  DIS_FRAME_LAST  = 5'h17;
  localparam logic [4:0]  DIS_FRAME_BITS  = 5'h18;
  localparam logic [4:0]  DIS_FIRST_DATA  = 5'h10;
  localparam int unsigned DIS_RD_FLAG     = 14;
  // register offsets
  localparam logic [14:0] DIS_ADDR_TRANSMIT_ENABLE_PIN   = 15'h0013;
  localparam logic [14:0] DIS_ADDR_PWR    = 15'h0014;
  localparam logic [14:0] DIS_ADDR_MASK_A = 15'h001F;
  localparam logic [14:0] DIS_ADDR_MASK_B = 15'h0020;
  localparam logic [14:0] DIS_ADDR_STAT_A = 15'h0023;
  localparam logic [14:0] DIS_ADDR_STAT_B = 15'h0024;
  // reset values and implemented-bit masks
  localparam logic [7:0]  DIS_RST_REG     = 8'h00;
  localparam logic [7:0]  DIS_TRANSMIT_ENABLE_PIN_IMPL   = 8'h03;
  localparam logic [7:0]  DIS_MASK_A_IMPL = 8'hDB;
  localparam logic [7:0]  DIS_MASK_B_IMPL = 8'hF8;
  // field positions
  localparam int unsigned DIS_TX_SEL      = 1;
  localparam int unsigned DIS_TX_VAL      = 0;
  localparam int unsigned DIS_PWR_DN_I    = 5;
  localparam int unsigned DIS_PWR_DN_Q    = 4;
  localparam int unsigned DIS_PWR_UP_I    = 1;
  localparam int unsigned DIS_PWR_UP_Q    = 0;
  localparam int unsigned DIS_A_CONV_LOSS = 7;
  localparam int unsigned DIS_A_CONV_LOCK = 6;
  localparam int unsigned DIS_A_LINK_LOSS = 4;
  localparam int unsigned DIS_A_LINK_LOCK = 3;
  localparam int unsigned DIS_A_LANE_ERR  = 1;
  localparam int unsigned DIS_A_DESK_ERR  = 0;
  localparam int unsigned DIS_B_BAD_PARAM = 7;
  localparam int unsigned DIS_B_LANE_LVL  = 6;
  localparam int unsigned DIS_B_DLY_LVL   = 5;
  localparam int unsigned DIS_B_DATA_VLD  = 4;
  localparam int unsigned DIS_B_DP_OVF    = 3;

  typedef enum logic [1:0] {DIS_SPI_IDLE, DIS_SPI_INSTR, DIS_SPI_DATA} dis_spi_st_t;

  function automatic logic dis_hit(input logic [14:0] a, input logic [14:0] off);
    return a == off;
  endfunction
endpackage
`default_nettype wire

// ===== logic/dis_spi_port.sv
// serial programming port: 16-bit instruction then one data byte, msb first
`default_nettype none
module dis_spi_port (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // pins
  input  wire logic                     sclk,
  input  wire logic                     csb_n,
  input  wire logic                     sdi,
  output logic                          sdo,
  output logic                          sdo_oe,
  // register side
  output logic [dis_pkg::DIS_AW-1:0]    reg_addr,
  output logic [dis_pkg::DIS_DW-1:0]    reg_wdata,
  output logic                          reg_wr,
  input  wire logic [dis_pkg::DIS_DW-1:0] reg_rdata
);
  import dis_pkg::*;

  logic                 sclk_q;
  logic                 rise;
  logic                 fall;
  dis_spi_st_t          st_q;
  logic [DIS_CNT_W-1:0] cnt_q;
  logic [15:0]          ins_q;
  logic [DIS_DW-1:0]    dat_q;
  logic [DIS_DW-1:0]    out_q;
  logic                 rd_q;
  logic                 load_q;

  // pins are synchronous to clk, sclk must stay >= 2 clk per phase
  assign rise = sclk & ~sclk_q & ~csb_n;
  assign fall = ~sclk & sclk_q & ~csb_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= DIS_SPI_IDLE;
    end else if (csb_n) begin
      st_q <= DIS_SPI_IDLE;
    end else begin
      case (st_q)
        DIS_SPI_IDLE: st_q <= DIS_SPI_INSTR;
        DIS_SPI_INSTR: begin
          if (rise && cnt_q == DIS_INSTR_LAST) begin
            st_q <= DIS_SPI_DATA;
          end
        end
        DIS_SPI_DATA: st_q <= DIS_SPI_DATA;
        default: st_q <= DIS_SPI_IDLE;
      endcase
    end
  end

  // bits after the first byte are ignored, no streaming
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (csb_n) begin
      cnt_q <= '0;
    end else if (rise && cnt_q != DIS_FRAME_BITS) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ins_q    <= '0;
      dat_q    <= '0;
      rd_q     <= 1'b0;
      reg_addr <= '0;
      load_q   <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (rise && cnt_q < DIS_FIRST_DATA) begin
        ins_q <= {ins_q[14:0], sdi};
      end
      if (rise && cnt_q >= DIS_FIRST_DATA && cnt_q <= DIS_FRAME_LAST) begin
        dat_q <= {dat_q[6:0], sdi};
      end
      if (rise && cnt_q == DIS_INSTR_LAST) begin
        rd_q     <= ins_q[DIS_RD_FLAG];
        reg_addr <= {ins_q[13:0], sdi};
        load_q   <= ins_q[DIS_RD_FLAG];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr    <= 1'b0;
      reg_wdata <= '0;
    end else begin
      reg_wr <= rise && cnt_q == DIS_FRAME_LAST && !rd_q;
      if (rise && cnt_q == DIS_FRAME_LAST) begin
        reg_wdata <= {dat_q[6:0], sdi};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
    end else if (load_q) begin
      out_q <= reg_rdata;
    end else if (fall && rd_q && cnt_q > DIS_FIRST_DATA) begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign sdo    = out_q[7];
  assign sdo_oe = (st_q == DIS_SPI_DATA) && rd_q && !csb_n;

  AST_SPI_WR_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr |-> !rd_q && $past(cnt_q) == DIS_FRAME_LAST)
    else $error("register write outside write frame");
endmodule // dis_spi_port
`default_nettype wire

// ===== logic/dis_top.sv
// converter irq enable, tx-enable override and power status registers
`default_nettype none
module dis_top (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // serial programming port
  input  wire logic spi_sclk,
  input  wire logic spi_csb_n,
  input  wire logic spi_sdi,
  output logic      spi_sdo,
  output logic      spi_sdo_oe,
  // transmit enable
  input  wire logic transmit_enable_pin,
  output logic      tx_enable,
  // converter power state
  input  wire logic i_chan_down_flag,
  input  wire logic q_chan_down_flag,
  input  wire logic i_chan_up_flag,
  input  wire logic q_chan_up_flag,
  // interrupt sources
  input  wire logic conv_pll_loss,
  input  wire logic conv_pll_lock,
  input  wire logic link_pll_loss,
  input  wire logic link_pll_lock,
  input  wire logic lane_buffer_err,
  input  wire logic deskew_buffer_err,
  input  wire logic bad_param,
  input  wire logic lane_buffer_level,
  input  wire logic delay_buffer_level,
  input  wire logic data_valid,
  input  wire logic datapath_ovf,
  // interrupt
  output logic      irq_n
);
  import dis_pkg::*;

  localparam logic [15:0] IMPL = {DIS_MASK_B_IMPL, DIS_MASK_A_IMPL};
  // power status bits that carry a flag, the rest read zero
  localparam logic [7:0]  PWR_USED = (8'h01 << DIS_PWR_DN_I) | (8'h01 << DIS_PWR_DN_Q)
                                   | (8'h01 << DIS_PWR_UP_I) | (8'h01 << DIS_PWR_UP_Q);

  logic              rst_meta_q;
  logic              rst_n_sync;
  logic [DIS_AW-1:0] reg_addr;
  logic [DIS_DW-1:0] reg_wdata;
  logic              reg_wr;
  logic [DIS_DW-1:0] reg_rdata;
  logic [7:0]        transmit_enable_pin_q;
  logic [7:0]        pwr_q;
  logic [7:0]        mask_a_q;
  logic [7:0]        mask_b_q;
  logic              tx_enable_q;
  logic              irq_n_q;
  logic [7:0]        src_a;
  logic [7:0]        src_b;
  logic [15:0]       en_all;
  logic [15:0]       src_all;
  logic [15:0]       clr_all;
  logic [15:0]       stat_all;
  logic [15:0]       lat_all;
  logic              any_pending;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_sync <= rst_meta_q;
    end
  end

  dis_spi_port u_spi (
    .clk       (sys_clk),
    .rst_n     (rst_n_sync),
    .sclk      (spi_sclk),
    .csb_n     (spi_csb_n),
    .sdi       (spi_sdi),
    .sdo       (spi_sdo),
    .sdo_oe    (spi_sdo_oe),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rdata (reg_rdata)
  );

  // software writable registers, unimplemented bits read zero
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      transmit_enable_pin_q   <= DIS_RST_REG;
      mask_a_q <= DIS_RST_REG;
      mask_b_q <= DIS_RST_REG;
    end else if (reg_wr) begin
      if (dis_hit(reg_addr, DIS_ADDR_TRANSMIT_ENABLE_PIN)) begin
        transmit_enable_pin_q <= reg_wdata & DIS_TRANSMIT_ENABLE_PIN_IMPL;
      end
      if (dis_hit(reg_addr, DIS_ADDR_MASK_A)) begin
        mask_a_q <= reg_wdata & DIS_MASK_A_IMPL;
      end
      if (dis_hit(reg_addr, DIS_ADDR_MASK_B)) begin
        mask_b_q <= reg_wdata & DIS_MASK_B_IMPL;
      end
    end
  end

  // override steers the internal enable
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      tx_enable_q <= 1'b0;
    end else if (transmit_enable_pin_q[DIS_TX_SEL]) begin
      tx_enable_q <= transmit_enable_pin_q[DIS_TX_VAL];
    end else begin
      tx_enable_q <= transmit_enable_pin;
    end
  end

  assign tx_enable = tx_enable_q;

  // power flags sampled every cycle, read only
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pwr_q <= DIS_RST_REG;
    end else begin
      pwr_q               <= DIS_RST_REG;
      pwr_q[DIS_PWR_DN_I] <= i_chan_down_flag;
      pwr_q[DIS_PWR_DN_Q] <= q_chan_down_flag;
      pwr_q[DIS_PWR_UP_I] <= i_chan_up_flag;
      pwr_q[DIS_PWR_UP_Q] <= q_chan_up_flag;
    end
  end

  // source to bit placement
  always_comb begin
    src_a                  = '0;
    src_b                  = '0;
    src_a[DIS_A_CONV_LOSS] = conv_pll_loss;
    src_a[DIS_A_CONV_LOCK] = conv_pll_lock;
    src_a[DIS_A_LINK_LOSS] = link_pll_loss;
    src_a[DIS_A_LINK_LOCK] = link_pll_lock;
    src_a[DIS_A_LANE_ERR]  = lane_buffer_err;
    src_a[DIS_A_DESK_ERR]  = deskew_buffer_err;
    src_b[DIS_B_BAD_PARAM] = bad_param;
    src_b[DIS_B_LANE_LVL]  = lane_buffer_level;
    src_b[DIS_B_DLY_LVL]   = delay_buffer_level;
    src_b[DIS_B_DATA_VLD]  = data_valid;
    src_b[DIS_B_DP_OVF]    = datapath_ovf;
  end

  assign en_all  = {mask_b_q, mask_a_q};
  assign src_all = {src_b, src_a};

  // status writes only clear; a written 0 is ignored
  always_comb begin
    clr_all = '0;
    if (reg_wr && dis_hit(reg_addr, DIS_ADDR_STAT_A)) begin
      clr_all[7:0] = reg_wdata;
    end
    if (reg_wr && dis_hit(reg_addr, DIS_ADDR_STAT_B)) begin
      clr_all[15:8] = reg_wdata;
    end
  end

  for (genvar i = 0; i < 16; i++) begin : g_src
    if (IMPL[i]) begin : g_cell
      dis_irq_cell u_cell (
        .clk     (sys_clk),
        .rst_n   (rst_n_sync),
        .en      (en_all[i]),
        .live    (src_all[i]),
        .clr     (clr_all[i]),
        .status  (stat_all[i]),
        .latched (lat_all[i])
      );
    end else begin : g_none
      assign stat_all[i] = 1'b0;
      assign lat_all[i]  = 1'b0;
    end
  end

  // a cell only latches while enabled, but keeps its flag one cycle after the enable drops; the gate hides it then
  assign any_pending = |(lat_all & en_all);

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~any_pending;
    end
  end

  assign irq_n = irq_n_q;

  // read mux, unmapped addresses read zero
  always_comb begin
    reg_rdata = '0;
    if (dis_hit(reg_addr, DIS_ADDR_TRANSMIT_ENABLE_PIN)) begin
      reg_rdata = transmit_enable_pin_q;
    end else if (dis_hit(reg_addr, DIS_ADDR_PWR)) begin
      reg_rdata = pwr_q;
    end else if (dis_hit(reg_addr, DIS_ADDR_MASK_A)) begin
      reg_rdata = mask_a_q;
    end else if (dis_hit(reg_addr, DIS_ADDR_MASK_B)) begin
      reg_rdata = mask_b_q;
    end else if (dis_hit(reg_addr, DIS_ADDR_STAT_A)) begin
      reg_rdata = stat_all[7:0];
    end else if (dis_hit(reg_addr, DIS_ADDR_STAT_B)) begin
      reg_rdata = stat_all[15:8];
    end
  end

  AST_TX_OVERRIDE: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    transmit_enable_pin_q[DIS_TX_SEL] |=> tx_enable == $past(transmit_enable_pin_q[DIS_TX_VAL]))
    else $error("tx enable ignores override value");
  AST_TX_PIN: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    !transmit_enable_pin_q[DIS_TX_SEL] |=> tx_enable == $past(transmit_enable_pin))
    else $error("tx enable ignores pin");
  AST_PWR_DN_I: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    i_chan_down_flag ##1 1'b1 |-> pwr_q[DIS_PWR_DN_I])
    else $error("i power-down status missing");
  AST_PWR_DN_Q: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    !q_chan_down_flag |=> !pwr_q[DIS_PWR_DN_Q])
    else $error("q power-down status stuck");
  AST_PWR_UP_I: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    1'b1 |=> pwr_q[DIS_PWR_UP_I] == $past(i_chan_up_flag))
    else $error("i power-up status wrong");
  AST_PWR_UP_Q: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    1'b1 |=> pwr_q[DIS_PWR_UP_Q] == $past(q_chan_up_flag))
    else $error("q power-up status wrong");
  AST_IRQ_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    en_all[DIS_A_CONV_LOSS] && $rose(conv_pll_loss)
      ##1 !clr_all[DIS_A_CONV_LOSS] && en_all[DIS_A_CONV_LOSS]
      |=> !irq_n)
    else $error("enabled pll loss did not pull interrupt low");
  AST_IRQ_DISABLED: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    en_all == 16'h0000 [*2] |=> irq_n)
    else $error("interrupt low with all sources disabled");
  AST_MASK_A_WR: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    reg_wr && dis_hit(reg_addr, DIS_ADDR_MASK_A)
      |=> mask_a_q == ($past(reg_wdata) & DIS_MASK_A_IMPL))
    else $error("mask a write lost");
  AST_MASK_B_WR: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    reg_wr && dis_hit(reg_addr, DIS_ADDR_MASK_B)
      |=> mask_b_q == ($past(reg_wdata) & DIS_MASK_B_IMPL))
    else $error("mask b write lost");
  AST_IRQ_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    !any_pending |=> irq_n)
    else $error("interrupt held with nothing pending");
  AST_IRQ_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    any_pending |=> !irq_n)
    else $error("interrupt high while a flag is pending");

  // enable must still stand one edge on, else the gate may mask the new flag
  AST_IRQ_CONV_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    mask_a_q[DIS_A_CONV_LOCK] && $rose(conv_pll_lock) ##1 mask_a_q[DIS_A_CONV_LOCK]
      |=> !irq_n)
    else $error("enabled converter pll lock did not pull interrupt low");
  AST_IRQ_LINK_LOSS: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    mask_a_q[DIS_A_LINK_LOSS] && $rose(link_pll_loss) ##1 mask_a_q[DIS_A_LINK_LOSS]
      |=> !irq_n)
    else $error("enabled link pll loss did not pull interrupt low");
  AST_IRQ_BAD_PARAM: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    mask_b_q[DIS_B_BAD_PARAM] && $rose(bad_param) ##1 mask_b_q[DIS_B_BAD_PARAM]
      |=> !irq_n)
    else $error("enabled bad parameter did not pull interrupt low");
  AST_IRQ_DP_OVF: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    mask_b_q[DIS_B_DP_OVF] && $rose(datapath_ovf) ##1 mask_b_q[DIS_B_DP_OVF]
      |=> !irq_n)
    else $error("enabled datapath overflow did not pull interrupt low");
  AST_MASK_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    (mask_a_q & ~DIS_MASK_A_IMPL) == 8'h00 && (mask_b_q & ~DIS_MASK_B_IMPL) == 8'h00)
    else $error("reserved mask bit set");
  AST_TRANSMIT_ENABLE_PIN_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    (transmit_enable_pin_q & ~DIS_TRANSMIT_ENABLE_PIN_IMPL) == 8'h00)
    else $error("reserved override bit set");
  AST_PWR_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    (pwr_q & ~PWR_USED) == 8'h00)
    else $error("reserved power status bit set");
  AST_STAT_A_LIVE: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    mask_a_q == 8'h00 && dis_hit(reg_addr, DIS_ADDR_STAT_A) |-> reg_rdata == src_a)
    else $error("status a does not show live sources");
  AST_STAT_B_LIVE: assert property (@(posedge sys_clk) disable iff (!rst_n_sync)
    mask_b_q == 8'h00 && dis_hit(reg_addr, DIS_ADDR_STAT_B) |-> reg_rdata == src_b)
    else $error("status b does not show live sources");
endmodule // dis_top
`default_nettype wire

// ===== tb/dis_top_test.sv
// self-checking bench for the irq enable, tx override and power status block
`default_nettype none
module dis_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dis_pkg::*;

  localparam int PH    = 4;      // sclk phase in sys_clk cycles, above the 2-cycle minimum
  localparam int LIMIT = 60000;  // about three times the expected run

  logic        sys_clk             = 1'b0;
  logic        rstn                = 1'b0;
  logic        spi_sclk            = 1'b0;
  logic        spi_csb_n           = 1'b1;
  logic        spi_sdi             = 1'b0;
  logic        transmit_enable_pin = 1'b0;
  logic [3:0]  pwr                 = 4'h0;
  logic [10:0] src                 = 11'h000;
  logic        spi_sdo;
  logic        spi_sdo_oe;
  logic        tx_enable;
  logic        irq_n;
  int          fails               = 0;
  int          comparisons         = 0;
  int          cycles              = 0;

  // source order: six mask A sources first, then mask B
  function automatic int src_bit(input int k);
    case (k)
      0:       return DIS_A_CONV_LOSS;
      1:       return DIS_A_CONV_LOCK;
      2:       return DIS_A_LINK_LOSS;
      3:       return DIS_A_LINK_LOCK;
      4:       return DIS_A_LANE_ERR;
      5:       return DIS_A_DESK_ERR;
      6:       return DIS_B_BAD_PARAM;
      7:       return DIS_B_LANE_LVL;
      8:       return DIS_B_DLY_LVL;
      9:       return DIS_B_DATA_VLD;
      default: return DIS_B_DP_OVF;
    endcase
  endfunction

  dis_top i_dut (
    .sys_clk(sys_clk), .rstn(rstn),
    .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .transmit_enable_pin(transmit_enable_pin), .tx_enable(tx_enable),
    .i_chan_down_flag(pwr[3]), .q_chan_down_flag(pwr[2]),
    .i_chan_up_flag(pwr[1]), .q_chan_up_flag(pwr[0]),
    .conv_pll_loss(src[0]), .conv_pll_lock(src[1]), .link_pll_loss(src[2]),
    .link_pll_lock(src[3]), .lane_buffer_err(src[4]), .deskew_buffer_err(src[5]),
    .bad_param(src[6]), .lane_buffer_level(src[7]), .delay_buffer_level(src[8]),
    .data_valid(src[9]), .datapath_ovf(src[10]),
    .irq_n(irq_n)
  );

  always #25 sys_clk = ~sys_clk;

  // a hang counts as a mismatch and ends the run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // returns on the edge: drives land by nba, reads see the settled pre-edge values
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic spi_xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                          output logic [7:0] rdat);
    logic [23:0] word;
    word = {rd, addr, wd};
    rdat = 8'h00;
    spi_csb_n <= 1'b0;
    wait_n(PH);
    for (int i = 0; i < 24; i++) begin
      spi_sdi <= word[23-i];
      wait_n(PH);
      spi_sclk <= 1'b1;
      wait_n(PH);
      if (rd && i >= 16)
        rdat[23-i] = spi_sdo;
      if (i == 16)
        chk("sdo_oe", {7'h00, rd}, {7'h00, spi_sdo_oe});
      spi_sclk <= 1'b0;
    end
    wait_n(PH);
    spi_csb_n <= 1'b1;
    spi_sdi   <= 1'b0;
    wait_n(2);
    chk("sdo_oe_idle", 8'h00, {7'h00, spi_sdo_oe});
  endtask

  task automatic wr(input logic [14:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    spi_xfer(1'b0, addr, data, unused);
  endtask

  task automatic rd_chk(input string what, input logic [14:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    spi_xfer(1'b1, addr, 8'h00, got);
    chk(what, exp, got);
  endtask

  task automatic irq_chk(input logic exp);
    chk("irq_n", {7'h00, exp}, {7'h00, irq_n});
  endtask

  task automatic t_reset();
    chk("tx_enable", 8'h00, {7'h00, tx_enable});
    irq_chk(1'b1);
    rd_chk("power", DIS_ADDR_PWR, 8'h00);
    rd_chk("mask_a", DIS_ADDR_MASK_A, 8'h00);
    rd_chk("mask_b", DIS_ADDR_MASK_B, 8'h00);
    rd_chk("transmit_enable_pin", DIS_ADDR_TRANSMIT_ENABLE_PIN, 8'h00);
  endtask

  task automatic t_regs();
    wr(DIS_ADDR_MASK_A, 8'hFF);
    rd_chk("mask_a", DIS_ADDR_MASK_A, DIS_MASK_A_IMPL);
    wr(DIS_ADDR_MASK_B, 8'hFF);
    rd_chk("mask_b", DIS_ADDR_MASK_B, DIS_MASK_B_IMPL);
    wr(DIS_ADDR_MASK_A, 8'h00);
    wr(DIS_ADDR_MASK_B, 8'h00);
    wr(DIS_ADDR_PWR, 8'hFF);
    rd_chk("power_ro", DIS_ADDR_PWR, 8'h00);
    rd_chk("unmapped", 15'h0055, 8'h00);
  endtask

  task automatic t_transmit_enable_pin();
    transmit_enable_pin <= 1'b1;
    wait_n(3);
    chk("tx_pin", 8'h01, {7'h00, tx_enable});
    wr(DIS_ADDR_TRANSMIT_ENABLE_PIN, 8'h02);
    chk("tx_ovr0", 8'h00, {7'h00, tx_enable});
    wr(DIS_ADDR_TRANSMIT_ENABLE_PIN, 8'h03);
    transmit_enable_pin <= 1'b0;
    wait_n(3);
    chk("tx_ovr1", 8'h01, {7'h00, tx_enable});
    wr(DIS_ADDR_TRANSMIT_ENABLE_PIN, 8'h01);
    chk("tx_back", 8'h00, {7'h00, tx_enable});
    wr(DIS_ADDR_TRANSMIT_ENABLE_PIN, 8'h00);
  endtask

  task automatic t_power();
    logic [3:0] p;
    for (int k = 0; k < 5; k++) begin
      p = (k == 4) ? 4'hF : 4'h1 << k;
      pwr <= p;
      wait_n(3);
      rd_chk("power", DIS_ADDR_PWR, {2'b00, p[3:2], 2'b00, p[1:0]});
    end
    pwr <= 4'h0;
  endtask

  task automatic t_live();
    src <= 11'h7FF;
    wait_n(3);
    rd_chk("live_a", DIS_ADDR_STAT_A, DIS_MASK_A_IMPL);
    rd_chk("live_b", DIS_ADDR_STAT_B, DIS_MASK_B_IMPL);
    irq_chk(1'b1);
    src <= 11'h000;
    wait_n(3);
    rd_chk("live_a0", DIS_ADDR_STAT_A, 8'h00);
  endtask

  task automatic t_latch();
    logic [7:0]  m;
    logic [14:0] mk;
    logic [14:0] st;
    for (int k = 0; k < 11; k++) begin
      m  = 8'h01 << src_bit(k);
      mk = (k < 6) ? DIS_ADDR_MASK_A : DIS_ADDR_MASK_B;
      st = (k < 6) ? DIS_ADDR_STAT_A : DIS_ADDR_STAT_B;
      wr(mk, m);
      src <= 11'h001 << k;
      wait_n(4);
      irq_chk(1'b0);
      src <= 11'h000;
      wait_n(3);
      rd_chk("latched", st, m);
      wr(st, 8'h00);
      irq_chk(1'b0);
      wr(st, m);
      wait_n(3);
      irq_chk(1'b1);
      rd_chk("cleared", st, 8'h00);
      wr(mk, 8'h00);
    end
  endtask

  task automatic t_two();
    wr(DIS_ADDR_MASK_A, 8'h80);
    wr(DIS_ADDR_MASK_B, 8'h08);
    src <= 11'h401;
    wait_n(4);
    wr(DIS_ADDR_STAT_A, 8'h80);
    wait_n(3);
    irq_chk(1'b0);
    wr(DIS_ADDR_STAT_B, 8'h08);
    wait_n(3);
    irq_chk(1'b1);
    src <= 11'h000;
  endtask

  initial begin
    wait_n(12);
    rstn <= 1'b1;
    wait_n(4);
    t_reset();
    t_regs();
    t_transmit_enable_pin();
    t_power();
    t_live();
    t_latch();
    t_two();
    give_verdict();
  end
endmodule // dis_top_test
`default_nettype wire
